//--- pch_cfg_regs.sv
// pch_cfg_regs: configuration header registers from the memory base upward
// Function
// RULE1 - memory base bits 31-12 read/write; 256-byte window repeats in 4 KB block
// RULE2 - memory base bits 11-4, prefetch bit 3 and space bit 0 read zero
// RULE3 - memory locate type field always reads 00, anywhere in 32-bit space
// RULE4 - expansion ROM base reads zero everywhere; reset clears it
// RULE5 - interrupt line byte is read/write, reset to zero
// RULE6 - interrupt pin byte is read-only and returns 1, first pin
// RULE7 - minimum grant byte is read-only and returns 4
// RULE8 - maximum latency byte is read-only and returns 4; any timer value works
// RULE9 - master works with any grant duration, one clock to parked
// RULE10 - feature config register read/write anytime, cleared only by bus reset
// RULE11 - config bit 7 is plain storage; bits 5, 4, 0 read zero
// RULE12 - plain read enable clear turns plain reads into read line commands
// RULE13 - after timer expiry and grant loss, master ends after current line
// RULE14 - parity invert test bit makes byte parity even, else odd
// RULE15 - internal memories store odd parity, checked and flagged on reads
// RULE16 - host writes every RAM byte before reading it after power-up
// RULE17 - dual address cycles used only when enabled and upper page nonzero
// RULE18 - termination polarity bit set gives active-low power output
// RULE19 - termination polarity cleared only by bus reset, not soft reset
// RULE20 - condition flags register read-only, reflects internal state
// RULE21 - latency timer held until frame asserts, reinitialised when it ends
// RULE22 - soft chip reset leaves configuration registers untouched
// RULE23 - registers reached by config cycles; writes to constant bits ignored
// assumes config cycles arrive as one-cycle requests on the core clock;
// frame and grant come from pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module pch_cfg_regs import pch_pkg::*; #(
  parameter int RAM_DEPTH = PCH_RAM_DEPTH,
  parameter int RAM_AW = PCH_RAM_AW
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration access
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack_q,
  output logic [31:0] cfg_rdata_q,
  // memory window decode
  input wire logic tgt_addr_valid,
  input wire logic [31:0] tgt_addr,
  output logic mem_hit_q,
  output logic [7:0] mem_reg_offset_q,
  // bus master timing, frame and grant are pins
  input wire logic frame_b,
  input wire logic gnt_b,
  input wire logic [7:0] latency_timer,
  input wire logic line_cmd_active,
  input wire logic line_done,
  output logic lat_expired_q,
  output logic bus_release_q,
  // master command generator
  input wire logic cmd_in_valid,
  input wire logic [3:0] cmd_in,
  output logic cmd_out_valid_q,
  output logic [3:0] cmd_out_q,
  // dual address cycle
  input wire logic [3:0] upper_addr_page,
  output logic dac_use_q,
  output logic [3:0] dac_page_q,
  // termination power
  input wire logic term_power_request,
  output logic term_power_output_q,
  // parity protected scratch memory
  input wire logic ram_we,
  input wire logic ram_re,
  input wire logic [RAM_AW-1:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata_q,
  output logic ram_rvalid_q,
  output logic ram_par_err_q
);

  logic rst_meta_q;
  logic rst_n;
  logic frame_meta_q;
  logic frame_sync_q;
  logic gnt_meta_q;
  logic gnt_sync_q;
  logic frame_act;
  logic gnt_act;
  logic [19:0] mem_base_q;
  logic [7:0] irq_line_q;
  logic [7:0] devcfg_q;
  logic [7:0] lat_cnt_q;
  logic [7:0] status;
  logic [31:0] rd_d;
  logic wr;
  logic [7:0] dev_wbyte;
  logic ram_err_raw;
  logic ram_err_seen_q;

  // reset release through two flops so every register leaves reset together
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // pin synchronisers; only the second stage is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_meta_q <= 1'b1;
      frame_sync_q <= 1'b1;
      gnt_meta_q <= 1'b1;
      gnt_sync_q <= 1'b1;
    end else begin
      frame_meta_q <= frame_b;
      frame_sync_q <= frame_meta_q;
      gnt_meta_q <= gnt_b;
      gnt_sync_q <= gnt_meta_q;
    end
  end

  assign frame_act = ~frame_sync_q;
  assign gnt_act = ~gnt_sync_q;
  assign wr = cfg_req & cfg_we;

  // writable bits of the feature byte only; constant bits drop the write
  assign dev_wbyte = (cfg_wdata[7:0] & PCH_DEVCFG_WMASK) | (devcfg_q & ~PCH_DEVCFG_WMASK);

  // memory window base, byte lanes 1..3 carry bits 31-12
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_base_q <= PCH_MEM_BASE_RST;
    end else if (wr && cfg_addr == PCH_OFS_MEM_BASE) begin
      if (cfg_be[1]) begin
        mem_base_q[3:0] <= cfg_wdata[15:12]; // RULE1
      end
      if (cfg_be[2]) begin
        mem_base_q[11:4] <= cfg_wdata[23:16]; // RULE1
      end
      if (cfg_be[3]) begin
        mem_base_q[19:12] <= cfg_wdata[31:24]; // RULE1
      end
    end
  end

  // interrupt line byte, lane 0 of the interrupt dword
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_line_q <= PCH_IRQ_LINE_RST; // RULE5
    end else if (wr && cfg_addr == PCH_OFS_IRQ && cfg_be[0]) begin
      irq_line_q <= cfg_wdata[7:0]; // RULE5
    end
  end

  // feature config: only the bus reset clears it, soft reset never reaches here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      devcfg_q <= PCH_DEVCFG_RST; // RULE10 RULE19 RULE22
    end else if (wr && cfg_addr == PCH_OFS_DEVCFG && cfg_be[0]) begin
      devcfg_q <= dev_wbyte; // RULE10 RULE11 RULE23
    end
  end

  // condition flags are live; nothing writes them
  always_comb begin
    status = 8'h00;
    status[PCH_STS_PAR_ERR] = ram_err_seen_q; // RULE20
    status[PCH_STS_LAT_EXP] = lat_expired_q;
    status[PCH_STS_DAC] = dac_use_q;
    status[PCH_STS_RELEASE] = bus_release_q;
  end

  // read data; constant fields are built here, never stored
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (cfg_addr)
      PCH_OFS_MEM_BASE: begin
        rd_d = {mem_base_q, 12'h000}; // RULE1 RULE2
        rd_d[2:1] = PCH_LOCATE_ANY32; // RULE3
      end
      PCH_OFS_ROM_BASE: begin
        rd_d = PCH_ROM_BASE_VAL; // RULE4
      end
      PCH_OFS_IRQ: begin
        rd_d = {PCH_MAX_LATENCY, PCH_MIN_GRANT, PCH_IRQ_PIN_FIRST, irq_line_q}; // RULE6 RULE7 RULE8
      end
      PCH_OFS_DEVCFG: begin
        rd_d = {16'h0000, status, devcfg_q}; // RULE11 RULE20
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // answer every config request one cycle later; reads of unmapped dwords give zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ack_q <= 1'b0;
      cfg_rdata_q <= 32'h0000_0000;
    end else begin
      cfg_ack_q <= cfg_req; // RULE23
      if (cfg_req && !cfg_we) begin
        cfg_rdata_q <= rd_d;
      end
    end
  end

  // window hit on bits 31-12; low byte repeats over the whole 4 KB block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_hit_q <= 1'b0;
      mem_reg_offset_q <= 8'h00;
    end else begin
      mem_hit_q <= tgt_addr_valid && tgt_addr[31:PCH_WIN_LSB] == mem_base_q; // RULE1
      mem_reg_offset_q <= tgt_addr[PCH_REG_OFS_W-1:0]; // RULE1
    end
  end

  // latency timer: loaded while frame is idle, counts down once frame asserts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_cnt_q <= 8'h00;
      lat_expired_q <= 1'b0;
    end else if (!frame_act) begin
      lat_cnt_q <= latency_timer; // RULE21 RULE8
      lat_expired_q <= 1'b0;
    end else begin
      if (lat_cnt_q != 8'h00) begin
        lat_cnt_q <= lat_cnt_q - 8'h01; // RULE21
      end
      lat_expired_q <= (lat_cnt_q == 8'h00);
    end
  end

  // release: grant gone after expiry, finishing a line command first.
  // grant length is never counted, so a one-clock or parked grant both work
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_release_q <= 1'b0;
    end else begin
      bus_release_q <= frame_act && lat_expired_q && !gnt_act
        && (!line_cmd_active || line_done); // RULE13 RULE9
    end
  end

  // command generator: plain reads become read line unless enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_out_valid_q <= 1'b0;
      cmd_out_q <= 4'h0;
    end else begin
      cmd_out_valid_q <= cmd_in_valid;
      if (cmd_in_valid) begin
        if (cmd_in == PCH_CMD_MEM_READ && !devcfg_q[PCH_CFG_PLAIN_RD]) begin
          cmd_out_q <= PCH_CMD_MEM_READ_LINE; // RULE12
        end else begin
          cmd_out_q <= cmd_in; // RULE12
        end
      end
    end
  end

  // dual address cycles only for a nonzero upper page
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_use_q <= 1'b0;
      dac_page_q <= 4'h0;
    end else begin
      dac_use_q <= devcfg_q[PCH_CFG_DAC] && upper_addr_page != 4'h0; // RULE17
      dac_page_q <= upper_addr_page;
    end
  end

  // termination power: polarity bit set means the output is active low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      term_power_output_q <= 1'b0;
    end else begin
      term_power_output_q <= term_power_request ^ devcfg_q[PCH_CFG_TERM_POL]; // RULE18
    end
  end

  // scratch memory; the invert bit reaches its parity generator
  pch_par_ram #(
    .DEPTH(RAM_DEPTH),
    .AW(RAM_AW)
  ) u_ram (
    .clk(clk),
    .rst_n(rst_n),
    .par_invert(devcfg_q[PCH_CFG_PAR_INV]), // RULE14
    .we(ram_we),
    .re(ram_re),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata_q(ram_rdata_q),
    .rvalid_q(ram_rvalid_q),
    .par_err_q(ram_err_raw)
  );

  // error flag mirrored to the port and held in status until the next read.
  // unwritten locations read garbage parity, so software must fill them first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_par_err_q <= 1'b0;
      ram_err_seen_q <= 1'b0;
    end else begin
      ram_par_err_q <= ram_err_raw; // RULE15 RULE16
      if (ram_rvalid_q) begin
        ram_err_seen_q <= ram_err_raw;
      end
    end
  end

  // checks next to the logic they guard
  a_ack_next_cycle: assert property (@(posedge clk) disable iff (!rst_n) // RULE23
    cfg_req |=> cfg_ack_q ##1 (!cfg_ack_q || $past(cfg_req)))
    else $error("config request not answered in one cycle");

  a_membase_low_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    (cfg_req && !cfg_we && cfg_addr == PCH_OFS_MEM_BASE) |=> cfg_rdata_q[11:0] == 12'h000)
    else $error("memory base low bits not zero");

  a_membase_rw: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    (wr && cfg_addr == PCH_OFS_MEM_BASE && cfg_be == 4'hF)
    |=> mem_base_q == $past(cfg_wdata[31:12]))
    else $error("memory base write not stored");

  a_rom_reads_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    (cfg_req && !cfg_we && cfg_addr == PCH_OFS_ROM_BASE) |=> cfg_rdata_q == 32'h0000_0000)
    else $error("rom base not zero");

  a_irq_dword_const: assert property (@(posedge clk) disable iff (!rst_n) // RULE6 RULE7 RULE8
    (cfg_req && !cfg_we && cfg_addr == PCH_OFS_IRQ) |=> cfg_rdata_q[31:8] == 24'h040401)
    else $error("pin, grant or latency byte wrong");

  a_irq_line_rw: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    (wr && cfg_addr == PCH_OFS_IRQ && cfg_be[0]) |=> irq_line_q == $past(cfg_wdata[7:0]))
    else $error("interrupt line not stored");

  a_devcfg_rsvd: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    (cfg_req && !cfg_we && cfg_addr == PCH_OFS_DEVCFG)
    |=> cfg_rdata_q[5:4] == 2'h0 && cfg_rdata_q[0] == 1'b0)
    else $error("reserved config bits not zero");

  a_cmd_convert: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    (cmd_in_valid && cmd_in == PCH_CMD_MEM_READ && !devcfg_q[PCH_CFG_PLAIN_RD])
    |=> cmd_out_valid_q && cmd_out_q == PCH_CMD_MEM_READ_LINE)
    else $error("plain read not converted");

  a_term_polarity: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
    term_power_output_q == ($past(term_power_request) ^ $past(devcfg_q[PCH_CFG_TERM_POL])))
    else $error("termination power polarity wrong");

  a_dac_page_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    (upper_addr_page == 4'h0) |=> !dac_use_q)
    else $error("dual address cycle with zero page");

  a_lat_reload: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
    (!frame_act) |=> lat_cnt_q == $past(latency_timer) && !lat_expired_q)
    else $error("latency timer not reinitialised");

  a_release_line: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    bus_release_q |-> $past(lat_expired_q && !gnt_act && (!line_cmd_active || line_done)))
    else $error("bus released before line done");

endmodule
`default_nettype wire

//--- pch_host_model.sv
// pch_host_model: host bridge side, issues config cycles and ram accesses
// assumes a free running clk and that the design's reset release is over
`timescale 1ns/1ps
`default_nettype none
module pch_host_model (
  // clock
  input wire logic clk,
  // config cycles
  output logic cfg_req,
  output logic cfg_we,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic cfg_ack_q,
  input wire logic [31:0] cfg_rdata_q,
  // scratch memory
  output logic ram_we,
  output logic ram_re,
  output logic [5:0] ram_addr,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata_q,
  input wire logic ram_rvalid_q,
  input wire logic ram_par_err_q
);
  int ack_miss = 0;

  // idle bus at time zero
  initial begin
    {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = '0;
    {ram_we, ram_re, ram_addr, ram_wdata} = '0;
  end

  // one config cycle; released fields are inverted so stale values never look valid
  task automatic cfg(input logic we, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    cfg_req <= 1'b1;
    cfg_we <= we;
    cfg_addr <= a;
    cfg_be <= 4'hF;
    cfg_wdata <= wd;
    @(posedge clk);
    cfg_req <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~wd;
    @(posedge clk);
    if (cfg_ack_q !== 1'b1) begin
      ack_miss++;
    end
    rd = cfg_rdata_q;
  endtask

  // a byte is always written before it is read, so its parity is defined
  task automatic ram_wr_rd(input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] rd, output logic rv, output logic pe);
    @(posedge clk);
    ram_we <= 1'b1;
    ram_addr <= a;
    ram_wdata <= d;
    @(posedge clk);
    ram_we <= 1'b0;
    ram_re <= 1'b1;
    ram_wdata <= ~d;
    @(posedge clk);
    ram_re <= 1'b0;
    ram_addr <= ~a;
    @(posedge clk);
    rd = ram_rdata_q;
    rv = ram_rvalid_q;
    @(posedge clk);
    pe = ram_par_err_q;
  endtask
endmodule
`default_nettype wire

//--- pch_par_ram.sv
// pch_par_ram: byte-wide memory that stores a parity bit beside each byte
// assumes synchronous reset copy from the top; contents are not reset
`timescale 1ns/1ps
`default_nettype none
module pch_par_ram import pch_pkg::*; #(
  parameter int DEPTH = PCH_RAM_DEPTH,
  parameter int AW = PCH_RAM_AW
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic par_invert,
  // access
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output logic par_err_q
);

  logic [8:0] mem [DEPTH];

  // odd parity normally; even when the test bit inverts it
  function automatic logic gen_par(input logic [7:0] d, input logic inv);
    gen_par = ~(^d) ^ inv;
  endfunction

  // write stores byte and generated parity
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= {gen_par(wdata, par_invert), wdata}; // RULE14 RULE15
    end
  end

  // read path: checker always expects odd parity, so inverted writes flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      par_err_q <= 1'b0;
    end else begin
      rvalid_q <= re;
      if (re) begin
        rdata_q <= mem[addr][7:0];
        par_err_q <= ~(^mem[addr]); // RULE15
      end else begin
        par_err_q <= 1'b0;
      end
    end
  end

  a_par_flag_odd: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    (re && !we && $stable(addr)) |=> (par_err_q == ~(^mem[$past(addr)])))
    else $error("parity flag does not follow stored byte");

endmodule
`default_nettype wire

//--- pch_pkg.sv
// pch_pkg: constants for the configuration header register bank
// assumes byte offsets of configuration dwords and a 250 MHz core clock
package pch_pkg;

  // configuration dword offsets (byte addresses)
  localparam logic [7:0] PCH_OFS_MEM_BASE = 8'h14;
  localparam logic [7:0] PCH_OFS_ROM_BASE = 8'h30;
  localparam logic [7:0] PCH_OFS_IRQ = 8'h3C;
  localparam logic [7:0] PCH_OFS_DEVCFG = 8'h40;

  // memory window base layout
  localparam int PCH_WIN_SPAN_BYTES = 4096;
  localparam int PCH_REG_SPAN_BYTES = 256;
  localparam int PCH_WIN_LSB = 12;
  localparam int PCH_REG_OFS_W = 8;
  localparam logic [19:0] PCH_MEM_BASE_RST = 20'h0_0000;
  localparam logic [1:0] PCH_LOCATE_ANY32 = 2'h0;
  localparam logic [1:0] PCH_LOCATE_BELOW_1M = 2'h1;
  localparam logic [1:0] PCH_LOCATE_ANY64 = 2'h2;

  // fixed values
  localparam logic [31:0] PCH_ROM_BASE_VAL = 32'h0000_0000;
  localparam logic [7:0] PCH_IRQ_LINE_RST = 8'h00;
  localparam logic [7:0] PCH_IRQ_PIN_FIRST = 8'h01;
  localparam logic [7:0] PCH_MIN_GRANT = 8'h04;
  localparam logic [7:0] PCH_MAX_LATENCY = 8'h04;

  // device feature config layout
  localparam logic [7:0] PCH_DEVCFG_RST = 8'h00;
  localparam logic [7:0] PCH_DEVCFG_WMASK = 8'hCE;
  localparam int PCH_CFG_SPARE = 7;
  localparam int PCH_CFG_PLAIN_RD = 6;
  localparam int PCH_CFG_PAR_INV = 3;
  localparam int PCH_CFG_DAC = 2;
  localparam int PCH_CFG_TERM_POL = 1;

  // condition flag positions
  localparam int PCH_STS_PAR_ERR = 0;
  localparam int PCH_STS_LAT_EXP = 1;
  localparam int PCH_STS_DAC = 2;
  localparam int PCH_STS_RELEASE = 3;

  // master read commands
  localparam logic [3:0] PCH_CMD_MEM_READ = 4'h6;
  localparam logic [3:0] PCH_CMD_MEM_READ_LINE = 4'hE;
  localparam logic [3:0] PCH_CMD_MEM_READ_MULT = 4'hC;

  // scratch memory geometry
  localparam int PCH_RAM_DEPTH = 64;
  localparam int PCH_RAM_AW = 6;

endpackage

//--- testbench.sv
// testbench: scenario tasks for the configuration header register bank
// assumes pch_pkg, pch_cfg_regs and pch_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pch_pkg::*;
  logic clk = 1'b0;
  // starts high so the first assignment in t_reset is a real falling edge at time zero;
  // otherwise the internal reset stays unknown until the first clock edge
  logic rst_b = 1'b1;
  logic tgt_addr_valid = 1'b0;
  logic [31:0] tgt_addr = '0;
  logic frame_b = 1'b1;
  logic gnt_b = 1'b1;
  logic [7:0] latency_timer = '0;
  logic line_cmd_active = 1'b0;
  logic line_done = 1'b0;
  logic cmd_in_valid = 1'b0;
  logic [3:0] cmd_in = '0;
  logic [3:0] upper_addr_page = '0;
  logic term_power_request = 1'b0;
  logic cfg_req, cfg_we, cfg_ack_q, mem_hit_q, lat_expired_q, bus_release_q;
  logic [7:0] cfg_addr, mem_reg_offset_q, ram_wdata, ram_rdata_q;
  logic [3:0] cfg_be, cmd_out_q, dac_page_q;
  logic [31:0] cfg_wdata, cfg_rdata_q;
  logic cmd_out_valid_q, dac_use_q, term_power_output_q;
  logic ram_we, ram_re, ram_rvalid_q, ram_par_err_q;
  logic [5:0] ram_addr;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  // design and host model
  pch_cfg_regs dut (.clk(clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack_q(cfg_ack_q),
    .cfg_rdata_q(cfg_rdata_q), .tgt_addr_valid(tgt_addr_valid), .tgt_addr(tgt_addr),
    .mem_hit_q(mem_hit_q), .mem_reg_offset_q(mem_reg_offset_q), .frame_b(frame_b),
    .gnt_b(gnt_b), .latency_timer(latency_timer), .line_cmd_active(line_cmd_active),
    .line_done(line_done), .lat_expired_q(lat_expired_q), .bus_release_q(bus_release_q),
    .cmd_in_valid(cmd_in_valid), .cmd_in(cmd_in), .cmd_out_valid_q(cmd_out_valid_q),
    .cmd_out_q(cmd_out_q), .upper_addr_page(upper_addr_page), .dac_use_q(dac_use_q),
    .dac_page_q(dac_page_q), .term_power_request(term_power_request),
    .term_power_output_q(term_power_output_q), .ram_we(ram_we), .ram_re(ram_re),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata_q(ram_rdata_q),
    .ram_rvalid_q(ram_rvalid_q), .ram_par_err_q(ram_par_err_q));
  pch_host_model host (.clk(clk), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack_q(cfg_ack_q),
    .cfg_rdata_q(cfg_rdata_q), .ram_we(ram_we), .ram_re(ram_re), .ram_addr(ram_addr[5:0]),
    .ram_wdata(ram_wdata), .ram_rdata_q(ram_rdata_q), .ram_rvalid_q(ram_rvalid_q),
    .ram_par_err_q(ram_par_err_q));

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  // hang guard, far above the roughly two hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic s);
    chk_word(n, {31'h0, e}, {31'h0, s});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    host.cfg(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.cfg(1'b0, a, 32'h0, d);
    chk_word(n, e, d);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // full bus reset at the end of the run as well as at start
  task automatic t_reset();
    rst_b <= 1'b0;
    tick(16);
    rst_b <= 1'b1;
    tick(4);
    rd_chk("mem_base", PCH_OFS_MEM_BASE, 32'h0);
    rd_chk("rom_base", PCH_OFS_ROM_BASE, 32'h0);
    rd_chk("irq_word", PCH_OFS_IRQ, 32'h0404_0100);
    rd_chk("devcfg", PCH_OFS_DEVCFG, 32'h0);
  endtask

  task automatic dec(input logic [31:0] a, input logic hit);
    @(posedge clk);
    tgt_addr_valid <= 1'b1;
    tgt_addr <= a;
    @(posedge clk);
    tgt_addr_valid <= 1'b0;
    tgt_addr <= ~a;
    @(posedge clk);
    chk_bit("mem_hit", hit, mem_hit_q);
    chk_word("reg_ofs", {24'h0, a[7:0]}, {24'h0, mem_reg_offset_q});
  endtask

  task automatic t_mem_base();
    wr(PCH_OFS_MEM_BASE, 32'hFFFF_FFFF);
    rd_chk("mem_base", PCH_OFS_MEM_BASE, 32'hFFFF_F000);
    wr(PCH_OFS_MEM_BASE, 32'h1234_5FFF);
    rd_chk("mem_base", PCH_OFS_MEM_BASE, 32'h1234_5000);
    dec(32'h1234_5A37, 1'b1);
    dec(32'h1234_6037, 1'b0);
    dec(32'h1234_4FC1, 1'b0);
  endtask

  task automatic t_const();
    wr(PCH_OFS_ROM_BASE, 32'hFFFF_FFFF);
    rd_chk("rom_base", PCH_OFS_ROM_BASE, 32'h0);
    wr(PCH_OFS_IRQ, 32'hFFFF_FFFF);
    rd_chk("irq_word", PCH_OFS_IRQ, 32'h0404_01FF);
    wr(PCH_OFS_IRQ, 32'h0000_000F);
    rd_chk("irq_word", PCH_OFS_IRQ, 32'h0404_010F);
    wr(PCH_OFS_DEVCFG, 32'hFFFF_FFFF);
    rd_chk("devcfg", PCH_OFS_DEVCFG, 32'h0000_00CE);
    wr(PCH_OFS_DEVCFG, 32'h0);
    rd_chk("devcfg", PCH_OFS_DEVCFG, 32'h0);
  endtask

  task automatic cmd(input logic [3:0] c, input logic [3:0] e);
    @(posedge clk);
    cmd_in_valid <= 1'b1;
    cmd_in <= c;
    @(posedge clk);
    cmd_in_valid <= 1'b0;
    cmd_in <= ~c;
    @(posedge clk);
    chk_bit("cmd_valid", 1'b1, cmd_out_valid_q);
    chk_word("cmd_out", {28'h0, e}, {28'h0, cmd_out_q});
  endtask

  task automatic t_cmd();
    cmd(4'h6, 4'hE);
    cmd(4'hE, 4'hE);
    cmd(4'hC, 4'hC);
    wr(PCH_OFS_DEVCFG, 32'h40);
    cmd(4'h6, 4'h6);
  endtask

  // dual address use and termination polarity both follow config bits
  task automatic t_dac_term();
    wr(PCH_OFS_DEVCFG, 32'h04);
    tick(2);
    chk_bit("dac_use", 1'b0, dac_use_q);
    upper_addr_page <= 4'h5;
    term_power_request <= 1'b1;
    tick(3);
    chk_bit("dac_use", 1'b1, dac_use_q);
    chk_word("dac_page", 32'h5, {28'h0, dac_page_q});
    chk_bit("term_pwr", 1'b1, term_power_output_q);
    wr(PCH_OFS_DEVCFG, 32'h02);
    tick(2);
    chk_bit("dac_use", 1'b0, dac_use_q);
    chk_bit("term_pwr", 1'b0, term_power_output_q);
    term_power_request <= 1'b0;
    tick(3);
    chk_bit("term_pwr", 1'b1, term_power_output_q);
    upper_addr_page <= 4'h0;
  endtask

  task automatic wait_exp();
    int n = 0;
    while (lat_expired_q !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk_bit("lat_expired", 1'b1, lat_expired_q);
  endtask

  task automatic t_lat();
    wr(PCH_OFS_DEVCFG, 32'h0);
    latency_timer <= 8'h02;
    gnt_b <= 1'b0;
    frame_b <= 1'b0;
    wait_exp();
    tick(3);
    chk_bit("release", 1'b0, bus_release_q);
    rd_chk("status", PCH_OFS_DEVCFG, 32'h0000_0200);
    gnt_b <= 1'b1;
    tick(5);
    chk_bit("release", 1'b1, bus_release_q);
    frame_b <= 1'b1;
    tick(5);
    chk_bit("lat_expired", 1'b0, lat_expired_q);
    chk_bit("release", 1'b0, bus_release_q);
    line_cmd_active <= 1'b1;
    frame_b <= 1'b0;
    wait_exp();
    tick(4);
    chk_bit("release", 1'b0, bus_release_q);
    line_done <= 1'b1;
    tick(3);
    chk_bit("release", 1'b1, bus_release_q);
    frame_b <= 1'b1;
    line_cmd_active <= 1'b0;
    line_done <= 1'b0;
    tick(5);
  endtask

  task automatic t_ram();
    logic [7:0] d;
    logic v;
    logic p;
    host.ram_wr_rd(6'h05, 8'hA5, d, v, p);
    chk_word("ram_data", 32'hA5, {24'h0, d});
    chk_bit("ram_valid", 1'b1, v);
    chk_bit("ram_par_err", 1'b0, p);
    wr(PCH_OFS_DEVCFG, 32'h08);
    host.ram_wr_rd(6'h3F, 8'h3C, d, v, p);
    chk_bit("ram_par_err", 1'b1, p);
    rd_chk("status", PCH_OFS_DEVCFG, 32'h0000_0108);
  endtask

  // main sequence
  initial begin
    t_reset();
    t_mem_base();
    t_const();
    t_cmd();
    t_dac_term();
    t_lat();
    t_ram();
    wr(PCH_OFS_DEVCFG, 32'h0000_00CE);
    t_reset();
    chk_word("ack_miss", 32'h0, host.ack_miss);
    stop_test();
  end
endmodule
`default_nettype wire
